// [sac_ctrl.sv]
// Serial converter control: select filter, frame timing, SAR, result shift
// Operation
// - Inputs above top reference give all ones, below bottom give zeros.
// - Select change counts only after held for setup plus two clocks.
// - Test addresses B, C, D give codes 512, 0 and 1023.
// - Conversion ends within 21 us; whole cycle within 21 us plus 10 clocks.
// - Acquisition lasts six serial clock periods.
// - Select falling within 9 us of edge ten aborts the conversion.
// - After select rises, clock and address are ignored once filtered.
// - Four address bits, MSB first, taken on the first four rising edges.
// - Sampling starts at edge four, sample held at edge ten.
// - Codes 0 to A pick external inputs; B, C, D pick test levels.
// - An aborted cycle returns to idle keeping the previous result.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  // Core clock domain
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic coreEn,
  // Serial link pins
  input wire logic ioClk,
  input wire logic csPin_b,
  input wire logic addrPin,
  output logic dataOut,
  output logic dataOutOe,
  output logic eoc,
  // Analog front end, as signed codes relative to the lower reference
  input wire sac_ana_t [N_EXT-1:0] anaIn,
  // Status
  output logic acqOn
);

  // ********************************************************************
  // Link domain: edge counter and address history
  // ********************************************************************
  sac_link_t lk, lkNx;

  always_comb begin
    lkNx = lk;
    lkNx.cnt = lk.cnt + 1'b1;
    lkNx.gray = lkNx.cnt ^ (lkNx.cnt >> 1);
    lkNx.hist = {lk.hist[ADDR_BITS-2:0], addrPin};
  end

  // Address is launched against this clock, so it is sampled directly
  always_ff @(posedge ioClk or negedge rst_b) begin
    if (!rst_b) begin
      lk <= '0;
    end else begin
      lk <= lkNx;
    end
  end

  // ********************************************************************
  // Core domain helpers
  // ********************************************************************
  function automatic sac_code_t clampCode(sac_ana_t a);
    if (a < 0) begin
      return CODE_ZERO;
    end
    if (a > $signed({2'b00, CODE_FULL})) begin
      return CODE_FULL;
    end
    return sac_code_t'(a);
  endfunction

  function automatic sac_code_t pickCode(logic [ADDR_BITS-1:0] a,
                                         sac_ana_t [N_EXT-1:0] ana);
    if (a <= ADDR_LAST_EXT) begin
      return clampCode(ana[a]);
    end
    unique case (a)
      ADDR_TEST_MID: return CODE_MID;
      ADDR_TEST_LO: return CODE_ZERO;
      ADDR_TEST_HI: return CODE_FULL;
      default: return CODE_ZERO;
    endcase
  endfunction

  // ********************************************************************
  // Core domain state
  // ********************************************************************
  sac_core_t st, nx;
  logic [CNT_W-1:0] curEdge, rel;
  logic csRise, bufInReady, bufOutValid, drain;
  logic [RES_BITS-1:0] bufOutData;
  sac_code_t trial;

  sac_buf #(
    .W(RES_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .coreEn(coreEn),
    .inValid(st.state == ST_PUSH),
    .inData(st.sar),
    .inReady(bufInReady),
    .outValid(bufOutValid),
    .outData(bufOutData),
    .outReady(drain)
  );

  always_comb begin
    nx = st;
    curEdge = grayToBin(st.graySync1);
    rel = curEdge - st.base;
    trial = st.sar | (sac_code_t'(1) << st.bitIdx);
    // Result word may only change while no data bit is being shifted;
    // edge zero lets a continuous 16-clock frame pick up its result
    drain = bufOutValid &&
            (!st.csActive || rel >= EDGE_HOLD || rel == '0);
    nx.csSync = {st.csSync[0], csPin_b};
    nx.graySync0 = lk.gray;
    nx.graySync1 = st.graySync0;

    // Select filter: a level must hold for the whole settle count
    csRise = 1'b0;
    if (!st.csSync[1] == st.csActive) begin
      nx.dbCnt = '0;
    end else if (st.dbCnt == ($clog2(DB_CYC))'(DB_CYC - 1)) begin
      nx.dbCnt = '0;
      nx.csActive = !st.csSync[1];
      csRise = !st.csSync[1];
    end else begin
      nx.dbCnt = st.dbCnt + 1'b1;
    end

    // Frame base: restarts on select, steps on in continuous styles
    if (csRise) begin
      nx.base = curEdge;
    end else if (st.csActive && rel == EDGE_FRAME) begin
      nx.base = st.base + EDGE_FRAME;
    end else if (drain && st.csActive && rel == EDGE_HOLD) begin
      // Ten-clock frame; a long frame that is still at ten loses sync
      nx.base = st.base + EDGE_HOLD;
    end

    if (drain) begin
      nx.outWord = bufOutData;
      nx.eoc = 1'b1;
    end

    nx.dataOutOe = st.csActive;
    if (st.csActive && rel < EDGE_HOLD) begin
      nx.dataOut = st.outWord[4'(RES_BITS - 1) - rel[3:0]];
    end else begin
      nx.dataOut = 1'b0;
    end

    unique case (st.state)
      ST_IDLE: begin
        if (st.csActive && !csRise && rel == EDGE_ADDR) begin
          nx.addr = lk.hist;
          nx.acqOn = 1'b1;
          nx.state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!st.csActive || csRise) begin
          nx.acqOn = 1'b0;
          nx.state = ST_IDLE;
        end else if (rel == EDGE_HOLD) begin
          nx.target = pickCode(st.addr, anaIn);
          nx.acqOn = 1'b0;
          nx.eoc = 1'b0;
          nx.sar = '0;
          nx.bitIdx = 4'(RES_BITS - 1);
          nx.stepCnt = '0;
          nx.elapsed = '0;
          nx.state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (st.elapsed < ($clog2(ABORT_CYC+1))'(ABORT_CYC)) begin
          nx.elapsed = st.elapsed + 1'b1;
        end
        if (csRise && st.elapsed < ($clog2(ABORT_CYC+1))'(ABORT_CYC)) begin
          // Abandon and keep the old result word untouched
          nx.eoc = 1'b1;
          nx.state = ST_IDLE;
        end else if (st.stepCnt == ($clog2(STEP_CYC))'(STEP_CYC - 1)) begin
          nx.stepCnt = '0;
          if (trial <= st.target) begin
            nx.sar = trial;
          end
          if (st.bitIdx == 4'h0) begin
            nx.state = ST_PUSH;
          end else begin
            nx.bitIdx = st.bitIdx - 1'b1;
          end
        end else begin
          nx.stepCnt = st.stepCnt + 1'b1;
        end
      end
      ST_PUSH: begin
        if (bufInReady) begin
          nx.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{csSync: 2'h3, eoc: 1'b1, state: ST_IDLE, default: '0};
    end else if (coreEn) begin
      st <= nx;
    end
  end

  assign dataOut = st.dataOut;
  assign dataOutOe = st.dataOutOe;
  assign eoc = st.eoc;
  assign acqOn = st.acqOn;

  // ********************************************************************
  // Checks
  // ********************************************************************
  localparam int ConvMax = CONV_CYC + 2;
  logic [CNT_W-1:0] relPast;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      relPast <= '0;
    end else begin
      relPast <= rel;
    end
  end

  logic convStart;
  assign convStart = (st.state == ST_ACQ) && (nx.state == ST_CONV);

  sequence eocLowTwo;
    !eoc ##1 !eoc;
  endsequence

  chk_cs_filter: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && $changed(st.csActive) |->
      $past(st.dbCnt) == ($clog2(DB_CYC))'(DB_CYC - 1))
    else $error("select level accepted before settle count");

  chk_conv_time: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && convStart |=>
      ##[1:ConvMax] (st.state != ST_CONV))
    else $error("conversion overran its time");

  chk_eoc_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && convStart |=> eocLowTwo)
    else $error("end flag not low at conversion start");

  chk_acq_start: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(acqOn) |-> relPast == EDGE_ADDR)
    else $error("acquisition did not open at edge four");

  chk_acq_close: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(acqOn) && st.state == ST_CONV |->
      relPast == EDGE_HOLD)
    else $error("sample not held at edge ten");

  chk_abort_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && st.state == ST_CONV && nx.state == ST_IDLE |=>
      $stable(st.outWord) && eoc)
    else $error("abort changed result or left flag low");

  chk_test_code: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && convStart && st.addr == ADDR_TEST_HI |=>
      st.target == CODE_FULL)
    else $error("test address gave wrong code");

  chk_cs_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && !st.csActive && st.state == ST_IDLE |=>
      st.state == ST_IDLE)
    else $error("cycle started with select inactive");

  chk_range_clamp: assert property (@(posedge core_clk) disable iff (!rst_b)
    coreEn && convStart && st.addr <= ADDR_LAST_EXT &&
      anaIn[st.addr] < 0 |=> st.target == CODE_ZERO)
    else $error("under-range input not zero");

  chk_addr_take: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(acqOn) |-> st.addr == $past(lk.hist))
    else $error("address not taken at edge four");

endmodule
`default_nettype wire

// [sac_pkg.sv]
// Shared constants, types and helpers for the serial converter control block
package sac_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CORE_MHZ = 40;
  localparam int CS_SETTLE_NS = 1425;
  localparam int DB_CYC = (CS_SETTLE_NS * CORE_MHZ + 999) / 1000;
  localparam int CONV_NS = 21000;
  localparam int RES_BITS = 10;
  localparam int CONV_CYC = CONV_NS * CORE_MHZ / 1000;
  localparam int STEP_CYC = CONV_CYC / RES_BITS;
  localparam int ABORT_NS = 9000;
  localparam int ABORT_CYC = ABORT_NS * CORE_MHZ / 1000;

  // ********************************************************************
  // Frame layout in serial clock edges
  // ********************************************************************
  localparam int ADDR_BITS = 4;
  localparam int N_EXT = 11;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] EDGE_ADDR = 5'h04;
  localparam logic [CNT_W-1:0] EDGE_HOLD = 5'h0A;
  localparam logic [CNT_W-1:0] EDGE_FRAME = 5'h10;
  localparam int BUF_DEPTH = 2;

  // ********************************************************************
  // Channel codes and result codes
  // ********************************************************************
  localparam logic [ADDR_BITS-1:0] ADDR_LAST_EXT = 4'hA;
  localparam logic [ADDR_BITS-1:0] ADDR_TEST_MID = 4'hB;
  localparam logic [ADDR_BITS-1:0] ADDR_TEST_LO = 4'hC;
  localparam logic [ADDR_BITS-1:0] ADDR_TEST_HI = 4'hD;
  localparam logic [RES_BITS-1:0] CODE_MID = 10'h200;
  localparam logic [RES_BITS-1:0] CODE_ZERO = 10'h000;
  localparam logic [RES_BITS-1:0] CODE_FULL = 10'h3FF;

  typedef logic signed [11:0] sac_ana_t;
  typedef logic [RES_BITS-1:0] sac_code_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_CONV = 4'b0100,
    ST_PUSH = 4'b1000
  } sac_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gray;
    logic [ADDR_BITS-1:0] hist;
  } sac_link_t;

  typedef struct packed {
    logic [1:0] csSync;
    logic [$clog2(DB_CYC)-1:0] dbCnt;
    logic csActive;
    logic [CNT_W-1:0] graySync0;
    logic [CNT_W-1:0] graySync1;
    logic [CNT_W-1:0] base;
    sac_state_t state;
    logic [$clog2(STEP_CYC)-1:0] stepCnt;
    logic [3:0] bitIdx;
    sac_code_t sar;
    sac_code_t target;
    logic [ADDR_BITS-1:0] addr;
    logic [$clog2(ABORT_CYC+1)-1:0] elapsed;
    sac_code_t outWord;
    logic eoc;
    logic dataOut;
    logic dataOutOe;
    logic acqOn;
  } sac_core_t;

  function automatic logic [CNT_W-1:0] grayToBin(logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// [sac_buf.sv]
// Small valid/ready buffer holding finished results
`timescale 1ns/1ps
`default_nettype none
module sac_buf
  import sac_pkg::*;
#(
  parameter int W = RES_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic coreEn,
  // Fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sac_buf_st_t;

  sac_buf_st_t st, nx;
  logic full, empty;

  always_comb begin
    nx = st;
    empty = (st.wp == st.rp);
    full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    inReady = !full;
    outValid = !empty;
    outData = st.mem[st.rp[AW-1:0]];
    if (inValid && !full) begin
      nx.mem[st.wp[AW-1:0]] = inData;
      nx.wp = st.wp + 1'b1;
    end
    if (outReady && !empty) begin
      nx.rp = st.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (coreEn) begin
      st <= nx;
    end
  end
endmodule
`default_nettype wire

// [sac_host.sv]
// Host serial port model: select, serial clock, address, result capture
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  // Core clock, used only to time select changes
  input wire logic core_clk,
  // Serial link pins
  output logic ioClk,
  output logic csPin_b,
  output logic addrPin,
  input wire logic dataOut,
  input wire logic dataOutOe,
  input wire logic acqOn
);
  initial begin
    ioClk = 1'b0;
    csPin_b = 1'b1;
    addrPin = 1'b0;
  end

  // ********************************************************************
  // Frame of n clocks, 160 ns period; rd[15] is sampled before rise one
  // ********************************************************************
  task automatic frame(input logic [3:0] a, input int n,
                       output logic [15:0] rd, output logic [2:0] acq);
    rd = '0;
    acq = '0;
    @(posedge core_clk) csPin_b <= 1'b0;
    // Odd offset keeps every sample clear of a core clock edge
    #2003;
    for (int k = 1; k <= n; k++) begin
      // Past bit four the line toggles so stray captures show up
      addrPin = (k <= 4) ? a[4-k] : ~addrPin;
      #70;
      // A released line reads high, as with a pull-up on the host side
      rd[16-k] = dataOutOe ? dataOut : 1'b1;
      if (k == 4 || k == 5 || k == 10) acq = {acqOn, acq[2:1]};
      ioClk = 1'b1;
      #80;
      ioClk = 1'b0;
      #10;
    end
  endtask

  // Clock pulses sent while the select is inactive
  task automatic pulses(input int n);
    repeat (n) begin
      #80 ioClk = 1'b1;
      #80 ioClk = 1'b0;
    end
  endtask

  task automatic setCs(input logic v);
    @(posedge core_clk) csPin_b <= v;
  endtask
endmodule
`default_nettype wire

// [sac_ctrl_tb.sv]
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_tb
  import sac_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic coreEn = 1'b1;
  logic ioClk, csPin_b, addrPin, dataOut, dataOutOe, eoc, acqOn;
  sac_ana_t [N_EXT-1:0] ana = '0;
  int n_errors = 0;
  int compares = 0;

  always #12.5 core_clk = ~core_clk;

  sac_ctrl sac_ctrl_i (.core_clk, .rst_b, .coreEn, .ioClk, .csPin_b,
    .addrPin, .dataOut, .dataOutOe, .eoc, .anaIn(ana), .acqOn);
  sac_host host_i (.core_clk, .ioClk, .csPin_b, .addrPin, .dataOut,
    .dataOutOe, .acqOn);

  // ********************************************************************
  // Shared helpers
  // ********************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One frame; the result read back belongs to the previous conversion
  task automatic xfer(input logic [3:0] a, input int n,
                      input logic [9:0] exp, input bit cmp);
    logic [15:0] rd;
    logic [2:0] acq;
    host_i.frame(a, n, rd, acq);
    if (cmp) chk(rd[15:6], exp);
    if (n == 16) chk(rd[5:0], '0);
    chk(acq, 3'b110);
    repeat (10) @(posedge core_clk);
    chk({eoc, acqOn}, 2'b00);
  endtask

  task automatic wait_conv;
    int c;
    c = 0;
    while (eoc !== 1'b1 && c < 1000) begin
      @(posedge core_clk);
      c++;
    end
    chk(c < 850, 1'b1);
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_codes;
    logic [3:0] adr [10] = '{4'hB, 4'hC, 4'hD, 4'h0, 4'h1, 4'hA, 4'h2, 4'h8,
                             4'hE, 4'hB};
    logic [9:0] exp [10] = '{10'h000, 10'h200, 10'h000, 10'h3FF,
                             10'h3FF, 10'h000, 10'h155, 10'h3FF,
                             10'h001, 10'h000};
    @(posedge core_clk);
    ana[0] <= 12'h7D0;
    ana[1] <= 12'hFFB;
    ana[2] <= 12'h3FF;
    ana[8] <= 12'h001;
    ana[10] <= 12'h155;
    for (int i = 0; i < 10; i++) begin
      xfer(adr[i], 10, exp[i], i > 0);
      host_i.setCs(1'b1);
      wait_conv();
      repeat (80) @(posedge core_clk);
    end
  endtask

  task automatic t_glitch;
    // Clock enable low must freeze the select filter
    @(posedge core_clk);
    coreEn <= 1'b0;
    host_i.setCs(1'b0);
    repeat (100) @(posedge core_clk);
    chk(dataOutOe, 1'b0);
    host_i.setCs(1'b1);
    repeat (4) @(posedge core_clk);
    coreEn <= 1'b1;
    repeat (10) @(posedge core_clk);
    host_i.setCs(1'b0);
    repeat (40) @(posedge core_clk);
    chk(dataOutOe, 1'b0);
    host_i.setCs(1'b1);
    repeat (80) @(posedge core_clk);
    host_i.pulses(10);
    repeat (10) @(posedge core_clk);
    chk({eoc, acqOn, dataOutOe}, 3'b100);
    ana[3] <= 12'h2A5;
    ana[9] <= 12'h2AA;
    ana[4] <= 12'h0CC;
    xfer(4'h3, 11, 10'h200, 1'b1);
    host_i.setCs(1'b1);
    wait_conv();
    repeat (80) @(posedge core_clk);
    // Continuous select, ten-clock frames
    xfer(4'h9, 10, 10'h2A5, 1'b1);
    wait_conv();
    xfer(4'h4, 10, 10'h2AA, 1'b1);
    host_i.setCs(1'b1);
    wait_conv();
    repeat (80) @(posedge core_clk);
  endtask

  task automatic t_abort;
    @(posedge core_clk);
    ana[5] <= 12'h123;
    ana[6] <= 12'h0F0;
    ana[7] <= 12'h0AB;
    xfer(4'h5, 10, 10'h0CC, 1'b1);
    host_i.setCs(1'b1);
    repeat (80) @(posedge core_clk);
    host_i.setCs(1'b0);
    repeat (80) @(posedge core_clk);
    chk(eoc, 1'b1);
    xfer(4'h6, 16, 10'h0CC, 1'b1);
    wait_conv();
    xfer(4'h7, 16, 10'h0F0, 1'b1);
    wait_conv();
    xfer(4'hF, 16, 10'h0AB, 1'b1);
    wait_conv();
    host_i.setCs(1'b1);
  endtask

  // ********************************************************************
  // Main sequence and watchdog
  // ********************************************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_codes();
    t_glitch();
    t_abort();
    repeat (20) @(posedge core_clk);
    tally_and_finish();
  end

  // The tests need about 0.5 ms; the margin covers slow conversions
  initial begin
    #1500000;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
